/* File: bench/serial_rtc_calendar_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_rtc_calendar_core_tb;
  import src_pkg::*;
  localparam logic [6:0] ADDR = 7'h68;
  localparam int TICK_RISES = (OSC_HZ + HUND_HZ - 1) / HUND_HZ;
  localparam logic [63:0] RST_TIME = 64'h00_00_00_00_01_01_01_00;
  // Rows: write pointer, read pointer, byte
  localparam logic [23:0] ROWS [6] = '{24'h01_01_59, 24'h02_02_34, 24'h0a_0a_23,
    24'h0d_0d_5a, 24'h11_11_a5, 24'h1f_00_45};
  // Rows: date, month, year, then expected date, month, year, hour byte
  localparam logic [55:0] ROLL [5] = '{56'h28_02_01_01_03_01_00, 56'h28_02_04_29_02_04_00,
    56'h29_02_04_01_03_04_00, 56'h30_04_21_01_05_21_00, 56'h31_12_99_01_01_00_40};
  logic clk, rst, osc, pwr_ok, sda_oe, sda_out, mfo_out, mfo_oe, on_bak, scl, host_low, ack;
  wire logic sda_w;
  logic [7:0] rbuf [8];
  logic [63:0] exp_t;
  int fail_count;
  int num_checks;
  assign sda_w = ~(host_low | sda_oe);
  src_i2c_host #(.HALF(10)) u_src_i2c_host (.i_sys_clk(clk), .i_sda(sda_w), .o_scl(scl),
    .o_sda_low(host_low));
  src_rtc_core u_src_rtc_core (.i_sys_clk(clk), .i_reset(rst), .i_scl(scl), .i_sda(sda_w),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_osc_in(osc), .i_main_power_ok(pwr_ok),
    .o_on_backup(on_bak), .o_multi_function_open_drain_out(mfo_out),
    .o_multi_function_open_drain_oe(mfo_oe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic addr_only(input logic [7:0] a, input logic exp);
    u_src_i2c_host.start();
    u_src_i2c_host.send_byte(a, ack);
    check("address ack", 8'(ack), 8'(exp));
    u_src_i2c_host.stop();
  endtask : addr_only
  task automatic wr(input logic [7:0] ptr, input logic [63:0] d, input int n);
    logic a;
    u_src_i2c_host.start();
    u_src_i2c_host.send_byte({ADDR, 1'b0}, a);
    ack = a;
    u_src_i2c_host.send_byte(ptr, a);
    ack &= a;
    for (int k = 0; k < n; k++) begin
      u_src_i2c_host.send_byte(d[63 - 8 * k -: 8], a);
      ack &= a;
    end
    u_src_i2c_host.stop();
    check("write ack", 8'(ack), 8'h01);
  endtask : wr
  task automatic rd(input logic [7:0] ptr, input int n);
    wr(ptr, 64'h0, 0);
    u_src_i2c_host.start();
    u_src_i2c_host.send_byte({ADDR, 1'b1}, ack);
    check("read ack", 8'(ack), 8'h01);
    for (int k = 0; k < n; k++) begin
      u_src_i2c_host.recv_byte(k == n - 1, rbuf[k]);
    end
    u_src_i2c_host.stop();
  endtask : rd
  // Oscillator far faster than a crystal, to keep runs short
  task automatic run_osc(input int n);
    repeat (n) begin
      repeat (5) @(posedge clk);
      #1 osc = 1'b1;
      repeat (5) @(posedge clk);
      #1 osc = 1'b0;
    end
    repeat (10) @(posedge clk);
    #1;
  endtask : run_osc
  task automatic check_time(input logic [63:0] e);
    rd(8'(OFS_HUND), 8);
    for (int k = 0; k < 8; k++) begin
      check("time byte", rbuf[k], e[63 - 8 * k -: 8]);
    end
  endtask : check_time
  initial begin
    #950_000;
    fail_count++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    osc = 1'b0;
    pwr_ok = 1'b1;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check("pin at reset", 8'(mfo_oe), 8'h00);
    check("pin data", 8'(mfo_out), 8'h00);
    check("sda data", 8'(sda_out), 8'h00);
    check_time(RST_TIME);
    foreach (ROWS[i]) begin
      wr(ROWS[i][23:16], {ROWS[i][7:0], 56'h0}, 1);
      rd(ROWS[i][15:8], 1);
      check("row readback", rbuf[0], ROWS[i][7:0]);
    end
    wr(8'(LAST_PTR), 64'h00_12_00_00_00_00_00_00, 2);
    rd(8'(LAST_PTR), 2);
    check("wrap byte", rbuf[1], 8'h12);
    wr(8'(OFS_CTRL), 64'h0, 1);
    check("pin driven", 8'(mfo_oe), 8'h01);
    wr(8'(OFS_CTRL), {RST_CTRL, 56'h0}, 1);
    check("pin released", 8'(mfo_oe), 8'h00);
    // Alarm at 00:00:00.00, hit by every rollover below
    wr(8'(OFS_AL_EN), 64'h80_00_00_00_00_00_00_00, 4);
    foreach (ROLL[i]) begin
      wr(8'(OFS_HUND), {32'h99_59_59_23, 8'h07, ROLL[i][55:32]}, 8);
      run_osc(TICK_RISES);
      exp_t = {24'h0, ROLL[i][7:0], 8'h01, ROLL[i][31:8]};
      check_time(exp_t);
    end
    check("alarm pin", 8'(mfo_oe), 8'h01);
    rd(8'(OFS_FLAGS), 1);
    check("alarm flag", rbuf[0], 8'(1 << BIT_AF));
    check("alarm cleared", 8'(mfo_oe), 8'h00);
    wr(8'(OFS_HUND), 64'h99_59_59_23_07_01_01_00, 8);
    pwr_ok = 1'b0;
    for (int w = 0; w < 20 && on_bak !== 1'b1; w++) begin
      @(posedge clk);
      #1;
    end
    check("on backup", 8'(on_bak), 8'h01);
    addr_only({ADDR, 1'b0}, 1'b0);
    run_osc(TICK_RISES);
    check("backup alarm", 8'(mfo_oe), 8'h01);
    pwr_ok = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    check("main supply", 8'(on_bak), 8'h00);
    check_time(64'h00_00_00_00_01_02_01_00);
    addr_only({ADDR ^ 7'h01, 1'b0}, 1'b0);
    close_out();
  end
endmodule : serial_rtc_calendar_core_tb
`default_nettype wire

/* File: bench/src_i2c_host.sv */
`timescale 1ns/1ps
`default_nettype none
module src_i2c_host #(
  parameter int unsigned HALF = 12
) (
  // System
  input wire logic i_sys_clk,
  // Bus wires
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic wait_half();
    repeat (HALF) @(posedge i_sys_clk);
    #1;
  endtask : wait_half
  // Start or repeated start, SDA falls while SCL is high
  task automatic start();
    wait_half();
    o_sda_low = 1'b0;
    wait_half();
    o_scl = 1'b1;
    wait_half();
    o_sda_low = 1'b1;
    wait_half();
    o_scl = 1'b0;
  endtask : start
  task automatic stop();
    wait_half();
    o_sda_low = 1'b1;
    wait_half();
    o_scl = 1'b1;
    wait_half();
    o_sda_low = 1'b0;
    wait_half();
  endtask : stop
  // Data moves only mid-low, away from the filtered SCL edge
  task automatic bit_io(input logic b, output logic s);
    wait_half();
    o_sda_low = ~b;
    wait_half();
    o_scl = 1'b1;
    wait_half();
    s = i_sda;
    o_scl = 1'b0;
  endtask : bit_io
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : send_byte
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask : recv_byte
endmodule : src_i2c_host
`default_nettype wire

/* File: rtl/src_pkg.sv */
package src_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned OSC_HZ = 32768;
  localparam int unsigned HUND_HZ = 100;
  localparam logic [15:0] ACC_STEP = 16'(HUND_HZ);
  localparam logic [15:0] ACC_MOD = 16'(OSC_HZ);
  localparam int unsigned REG_COUNT = 20;
  localparam int unsigned TIME_BYTES = 8;
  localparam logic [4:0] LAST_PTR = 5'(REG_COUNT - 1);
  // Byte map
  localparam logic [4:0] OFS_HUND = 5'h00;
  localparam logic [4:0] OFS_SEC = 5'h01;
  localparam logic [4:0] OFS_MIN = 5'h02;
  localparam logic [4:0] OFS_HOUR = 5'h03;
  localparam logic [4:0] OFS_DAY = 5'h04;
  localparam logic [4:0] OFS_DATE = 5'h05;
  localparam logic [4:0] OFS_MONTH = 5'h06;
  localparam logic [4:0] OFS_YEAR = 5'h07;
  localparam logic [4:0] OFS_CTRL = 5'h08;
  localparam logic [4:0] OFS_AL_EN = 5'h09;
  localparam logic [4:0] OFS_AL_HOUR = 5'h0a;
  localparam logic [4:0] OFS_AL_MIN = 5'h0b;
  localparam logic [4:0] OFS_AL_SEC = 5'h0c;
  localparam logic [4:0] OFS_FLAGS = 5'h0f;
  localparam logic [4:0] OFS_SQW = 5'h13;
  // Field positions
  localparam int unsigned BIT_OUT_LVL = 7;
  localparam int unsigned BIT_FT_EN = 6;
  localparam int unsigned BIT_AL_EN = 7;
  localparam int unsigned BIT_AF = 6;
  localparam int unsigned BIT_SQW_EN = 0;
  localparam int unsigned FT_DIV_BIT = 6;
  // Reset values
  localparam logic [7:0] RST_ONE = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h80;

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_PTR, S_WDAT, S_ACK, S_READ, S_RACK
  } src_i2c_e;
endpackage : src_pkg

/* File: rtl/src_rtc_core.sv */
`timescale 1ns/1ps
`default_nettype none
module src_rtc_core #(
  parameter logic [6:0] DEV_ADDR = 7'h68
) (
  // System
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Two-wire bus
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Time base and supply
  input wire logic i_osc_in,
  input wire logic i_main_power_ok,
  output logic o_on_backup,
  // Multi-function pin
  output logic o_multi_function_open_drain_out,
  output logic o_multi_function_open_drain_oe
);
  import src_pkg::*;

  initial begin
    if (CLK_HZ < 8 * OSC_HZ) $error("System clock too slow to sample the oscillator");
  end

  typedef struct packed {
    logic [2:0] scl_s, sda_s, osc_s, pwr_s;
    logic scl_f, sda_f, osc_f, pwr_f;
    logic [15:0] acc;
    logic tick;
    logic [6:0] ft_cnt;
    logic [TIME_BYTES-1:0][7:0] snap;
    logic [REG_COUNT-1:0][7:0] regs;
    src_i2c_e st, nxt;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic [4:0] ptr;
    logic sda_oe, mfo_oe, backup;
  } src_state_s;

  src_state_s q, d;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction : bcd_inc

  function automatic logic is_leap(input logic [7:0] y);
    // Every fourth year; 2100 is not caught, hence the limit
    return y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
  endfunction : is_leap

  function automatic logic [7:0] last_date(input logic [7:0] m, input logic leap);
    case (m)
      8'h02: return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction : last_date

  function automatic logic [4:0] ptr_next(input logic [4:0] p);
    return (p >= LAST_PTR) ? 5'h00 : p + 5'h01;
  endfunction : ptr_next

  logic scl_rise, scl_fall, sda_rise, sda_fall, osc_rise, c, do_write;
  logic [15:0] acc_sum;
  logic [7:0] tmp, rbyte;

  always_comb begin
    d = q;
    c = 1'b0;
    tmp = 8'h00;
    rbyte = 8'h00;
    do_write = 1'b0;
    acc_sum = 16'h0000;
    d.scl_s = {q.scl_s[1:0], i_scl};
    d.sda_s = {q.sda_s[1:0], i_sda};
    d.osc_s = {q.osc_s[1:0], i_osc_in};
    d.pwr_s = {q.pwr_s[1:0], i_main_power_ok};
    if (q.scl_s[2] == q.scl_s[1]) d.scl_f = q.scl_s[2];
    if (q.sda_s[2] == q.sda_s[1]) d.sda_f = q.sda_s[2];
    if (q.osc_s[2] == q.osc_s[1]) d.osc_f = q.osc_s[2];
    if (q.pwr_s[2] == q.pwr_s[1]) d.pwr_f = q.pwr_s[2];
    scl_rise = !q.scl_f && d.scl_f;
    scl_fall = q.scl_f && !d.scl_f;
    sda_rise = !q.sda_f && d.sda_f && d.scl_f;
    sda_fall = q.sda_f && !d.sda_f && d.scl_f;
    osc_rise = !q.osc_f && d.osc_f;
    d.backup = !d.pwr_f;

    // Fractional divider: 100 hundredths per 32768 crystal cycles
    d.tick = 1'b0;
    if (osc_rise) begin
      d.ft_cnt = q.ft_cnt + 7'h01;
      acc_sum = q.acc + ACC_STEP;
      if (acc_sum >= ACC_MOD) begin
        d.tick = 1'b1;
        d.acc = acc_sum - ACC_MOD;
      end else begin
        d.acc = acc_sum;
      end
    end

    // Counter chain keeps running on backup as well
    c = d.tick;
    if (c) begin
      c = (q.regs[OFS_HUND] == 8'h99);
      d.regs[OFS_HUND] = c ? 8'h00 : bcd_inc(q.regs[OFS_HUND]);
    end
    if (c) begin
      c = (q.regs[OFS_SEC] == 8'h59);
      d.regs[OFS_SEC] = c ? 8'h00 : bcd_inc(q.regs[OFS_SEC]);
    end
    if (c) begin
      c = (q.regs[OFS_MIN] == 8'h59);
      d.regs[OFS_MIN] = c ? 8'h00 : bcd_inc(q.regs[OFS_MIN]);
    end
    if (c) begin
      c = (q.regs[OFS_HOUR][5:0] == 6'h23);
      tmp = bcd_inc({2'b00, q.regs[OFS_HOUR][5:0]});
      d.regs[OFS_HOUR][5:0] = c ? 6'h00 : tmp[5:0];
    end
    if (c) begin
      d.regs[OFS_DAY] = (q.regs[OFS_DAY] == 8'h07) ? RST_ONE : bcd_inc(q.regs[OFS_DAY]);
      c = (q.regs[OFS_DATE] == last_date(q.regs[OFS_MONTH], is_leap(q.regs[OFS_YEAR])));
      d.regs[OFS_DATE] = c ? RST_ONE : bcd_inc(q.regs[OFS_DATE]);
    end
    if (c) begin
      c = (q.regs[OFS_MONTH] == 8'h12);
      d.regs[OFS_MONTH] = c ? RST_ONE : bcd_inc(q.regs[OFS_MONTH]);
    end
    if (c) begin
      c = (q.regs[OFS_YEAR] == 8'h99);
      d.regs[OFS_YEAR] = c ? 8'h00 : bcd_inc(q.regs[OFS_YEAR]);
    end
    if (c) d.regs[OFS_HOUR][7:6] = q.regs[OFS_HOUR][7:6] + 2'b01;

    // Two-wire slave
    if (scl_rise) begin
      unique case (q.st)
        S_ADDR, S_PTR, S_WDAT: begin
          d.sh = {q.sh[6:0], q.sda_f};
          d.bcnt = q.bcnt + 4'h1;
        end
        S_RACK: d.st = q.sda_f ? S_IDLE : S_ACK;
        default: ;
      endcase
    end
    if (scl_fall) begin
      unique case (q.st)
        S_ADDR, S_PTR, S_WDAT: if (q.bcnt == 4'h8) begin
          d.bcnt = 4'h0;
          d.sda_oe = 1'b1;
          d.st = S_ACK;
          if (q.st == S_ADDR) begin
            if (q.sh[7:1] != DEV_ADDR) begin
              d.sda_oe = 1'b0;
              d.st = S_IDLE;
            end else if (q.sh[0]) begin
              d.nxt = S_READ;
              d.snap = q.regs[TIME_BYTES-1:0];
            end else begin
              d.nxt = S_PTR;
            end
          end else if (q.st == S_PTR) begin
            d.ptr = (q.sh[4:0] > LAST_PTR) ? 5'h00 : q.sh[4:0];
            d.nxt = S_WDAT;
          end else begin
            do_write = 1'b1;
            d.ptr = ptr_next(q.ptr);
          end
        end
        S_ACK: begin
          d.sda_oe = 1'b0;
          d.st = q.nxt;
          if (q.nxt == S_READ) begin
            rbyte = (q.ptr < 5'(TIME_BYTES)) ? q.snap[q.ptr[2:0]] : q.regs[q.ptr];
            if (q.ptr == OFS_FLAGS) d.regs[OFS_FLAGS][BIT_AF] = 1'b0;
            d.sh = {rbyte[6:0], 1'b0};
            d.sda_oe = !rbyte[7];
            d.bcnt = 4'h1;
            d.ptr = ptr_next(q.ptr);
          end
        end
        S_READ: begin
          if (q.bcnt == 4'h8) begin
            d.sda_oe = 1'b0;
            d.st = S_RACK;
          end else begin
            d.sda_oe = !q.sh[7];
            d.sh = {q.sh[6:0], 1'b0};
            d.bcnt = q.bcnt + 4'h1;
          end
        end
        default: ;
      endcase
    end
    if (do_write) d.regs[q.ptr] = q.sh;
    if (sda_fall) begin
      d.st = S_ADDR;
      d.bcnt = 4'h0;
      d.sda_oe = 1'b0;
    end
    if (sda_rise || d.backup) begin
      d.st = S_IDLE;
      d.sda_oe = 1'b0;
    end

    // Alarm set wins over a clearing read
    if (q.tick && q.regs[OFS_HUND] == 8'h00 && q.regs[OFS_AL_EN][BIT_AL_EN]
        && q.regs[OFS_HOUR][5:0] == q.regs[OFS_AL_HOUR][5:0]
        && q.regs[OFS_MIN] == q.regs[OFS_AL_MIN]
        && q.regs[OFS_SEC] == q.regs[OFS_AL_SEC]) begin
      d.regs[OFS_FLAGS][BIT_AF] = 1'b1;
    end

    // Pin priority: alarm, frequency test, square wave, plain level
    if (q.regs[OFS_AL_EN][BIT_AL_EN] && q.regs[OFS_FLAGS][BIT_AF]) d.mfo_oe = 1'b1;
    else if (q.regs[OFS_CTRL][BIT_FT_EN]) d.mfo_oe = !q.ft_cnt[FT_DIV_BIT];
    else if (q.regs[OFS_SQW][BIT_SQW_EN]) d.mfo_oe = (q.regs[OFS_HUND][7:4] >= 4'h5);
    else d.mfo_oe = !q.regs[OFS_CTRL][BIT_OUT_LVL];
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      q <= '0;
      q.scl_s <= 3'b111;
      q.sda_s <= 3'b111;
      q.pwr_s <= 3'b111;
      q.scl_f <= 1'b1;
      q.sda_f <= 1'b1;
      q.pwr_f <= 1'b1;
      q.st <= S_IDLE;
      q.nxt <= S_IDLE;
      q.regs[OFS_DAY] <= RST_ONE;
      q.regs[OFS_DATE] <= RST_ONE;
      q.regs[OFS_MONTH] <= RST_ONE;
      q.regs[OFS_CTRL] <= RST_CTRL;
    end else begin
      q <= d;
    end
  end

  assign o_sda_out = 1'b0;
  assign o_multi_function_open_drain_out = 1'b0;
  assign o_sda_oe = q.sda_oe;
  assign o_on_backup = q.backup;
  assign o_multi_function_open_drain_oe = q.mfo_oe;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  sequence hund_wrap_s;
    q.tick == 1'b0 ##0 d.tick && q.regs[OFS_HUND] == 8'h99 && !do_write;
  endsequence
  sequence feb_end_s;
    d.tick && q.regs[OFS_HUND] == 8'h99 && q.regs[OFS_SEC] == 8'h59
      && q.regs[OFS_MIN] == 8'h59 && q.regs[OFS_HOUR][5:0] == 6'h23
      && q.regs[OFS_MONTH] == 8'h02 && q.regs[OFS_DATE] == 8'h28
      && !is_leap(q.regs[OFS_YEAR]) && !do_write;
  endsequence

  a_bcd_digits: assert property (q.regs[OFS_SEC][3:0] <= 4'h9 && q.regs[OFS_MIN][3:0] <= 4'h9)
    else $error("Time byte holds a non-BCD digit");
  a_ctrl_store: assert property (do_write && q.ptr == OFS_CTRL |=> q.regs[OFS_CTRL] == $past(q.sh))
    else $error("Control byte write lost");
  a_ptr_advance: assert property (do_write && q.ptr < LAST_PTR |=> q.ptr == $past(q.ptr) + 5'h01)
    else $error("Pointer did not advance after a written byte");
  a_hund_rollover: assert property (hund_wrap_s |=> q.regs[OFS_HUND] == 8'h00)
    else $error("Hundredths did not wrap to zero");
  a_feb_rollover: assert property (feb_end_s |=> q.regs[OFS_DATE] == RST_ONE && q.regs[OFS_MONTH] == 8'h03)
    else $error("Short February did not roll to March");
  a_addr_nack: assert property (scl_fall && q.st == S_ADDR && q.bcnt == 4'h8
      && q.sh[7:1] != DEV_ADDR |=> !o_sda_oe && q.st == S_IDLE)
    else $error("Foreign address acknowledged");
  a_tick_source: assert property (q.tick |-> $past(osc_rise))
    else $error("Hundredth tick without an oscillator edge");
  a_alarm_pin: assert property (q.regs[OFS_AL_EN][BIT_AL_EN] && q.regs[OFS_FLAGS][BIT_AF]
      ##1 q.regs[OFS_AL_EN][BIT_AL_EN] |-> o_multi_function_open_drain_oe)
    else $error("Alarm flag not driven on the pin");
  a_alarm_backup: assert property (q.backup && q.tick && q.regs[OFS_HUND] == 8'h00
      && q.regs[OFS_AL_EN][BIT_AL_EN] && q.regs[OFS_SEC] == q.regs[OFS_AL_SEC]
      && q.regs[OFS_MIN] == q.regs[OFS_AL_MIN]
      && q.regs[OFS_HOUR][5:0] == q.regs[OFS_AL_HOUR][5:0] |=> q.regs[OFS_FLAGS][BIT_AF])
    else $error("Alarm missed on backup supply");
  a_backup_deselect: assert property (q.backup |=> !o_sda_oe && q.st == S_IDLE)
    else $error("Bus still served on backup supply");
  a_snap_stable: assert property (q.st == S_READ ##1 q.st == S_READ |-> $stable(q.snap))
    else $error("Snapshot changed during a read");
endmodule : src_rtc_core
`default_nettype wire
